// ---- hdl/acscc_map.svh ----
// Register offsets, field positions, reset values and rate constants for the clock source block
`ifndef ACSCC_MAP_SVH
`define ACSCC_MAP_SVH

// Register offsets
`define ACSCC_OFF_SOURCE_CFG   8'h34
`define ACSCC_OFF_CTRL_CFG0    8'h35
`define ACSCC_OFF_CTRL_CFG1    8'h36
`define ACSCC_OFF_CTRL_CFG2    8'h37
`define ACSCC_OFF_ERR_STATUS   8'h3c

// Reset values
`define ACSCC_RST_SOURCE_CFG   8'h40
`define ACSCC_RST_CTRL_CFG0    8'h00
`define ACSCC_RST_CTRL_CFG1    8'h00
`define ACSCC_RST_CTRL_CFG2    8'h20

// Field positions in the source configuration register
`define ACSCC_BIT_PLL_OFF      7
`define ACSCC_BIT_FRAC_PERMIT  6
`define ACSCC_SRC_HI           3
`define ACSCC_SRC_LO           1
`define ACSCC_BIT_EDGE         0

// Field positions in controller configuration registers and the error status register
`define ACSCC_PDM_HI           7
`define ACSCC_PDM_LO           6
`define ACSCC_RATIO_HIGH_HI    5
`define ACSCC_FREQ_HI          7
`define ACSCC_FREQ_LO          5
`define ACSCC_BIT_PRI_ROLE     4
`define ACSCC_BIT_SEC_ROLE     3
`define ACSCC_BIT_FAMILY       0
`define ACSCC_BIT_RATIO_ERR    7

// Reference source codes
`define ACSCC_SRC_PRI_BCLK     3'h0
`define ACSCC_SRC_REF_PRI      3'h1
`define ACSCC_SRC_SEC_BCLK     3'h2
`define ACSCC_SRC_REF_SEC      3'h3
`define ACSCC_SRC_FIXED_REF    3'h4
`define ACSCC_SRC_INT_OSC      3'h5

// Reference frequency per code, in kHz
`define ACSCC_FREQ_KHZ_TABLE   {15'h6000, 15'h5dc0, 15'h4ce0, 15'h4b00, \
                                15'h3e80, 15'h32c8, 15'h3000, 15'h2ee0}

// Phase step of the pdm clock oscillator at a 250 MHz system clock, 32-bit phase
`define ACSCC_SYS_CLOCK_HZ     250000000
`define ACSCC_PDM_BASE_48K_HZ  3072000
`define ACSCC_PDM_BASE_44K_HZ  2822400
`define ACSCC_PDM_STEP_48K     32'h03254e6e
`define ACSCC_PDM_STEP_44K     32'h02e3e00f

`endif

// ---- hdl/acscc_pkg.sv ----
// Types shared by the clock source configuration block
package acscc_pkg;

  // Clocking controls driven to the rest of the codec
  typedef struct packed {
    logic        pll_enable;
    logic        pll_fractional_permit;
    logic        primary_port_role;
    logic        secondary_port_role;
    logic        rate_family_select;
    logic [14:0] ref_freq_khz;
    logic [13:0] ref_ratio;
    logic        ref_ratio_auto;
  } acscc_clk_ctrl_type;

  // States of the ratio checker
  typedef enum logic [1:0] {
    acscc_idle,
    acscc_first_frame,
    acscc_measure
  } acscc_check_state_type;

endpackage

// ---- hdl/acscc_pdm_clock.sv ----
// Phase accumulator that makes the pdm bit clock from the system clock
`timescale 1ns/1ps
`include "acscc_map.svh"

module acscc_pdm_clock
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] pdm_rate_choice,
  input  wire logic       rate_family_select,
  output logic            pdm_bit_clock
);

  logic [31:0] base_step;
  logic [31:0] step;
  logic [31:0] phase;

  // Rate from family and code; the fractional step keeps long-term frequency exact
  always_comb
  begin
    base_step = rate_family_select ? `ACSCC_PDM_STEP_44K : `ACSCC_PDM_STEP_48K;
    unique case (pdm_rate_choice)
      2'h0:    step = base_step;
      2'h1:    step = base_step >> 1;
      2'h2:    step = base_step >> 2;
      2'h3:    step = {base_step[30:0], 1'b0};
    endcase
  end

  // Accumulate phase
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      phase <= 32'h0;
    else
      phase <= phase + step;
  end

  // Clock is the phase top bit; edges jitter by one system period
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pdm_bit_clock <= 1'b0;
    else
      pdm_bit_clock <= phase[31];
  end

endmodule // acscc_pdm_clock

// ---- hdl/acscc_ratio_check.sv ----
// Counts source clock edges per frame and flags a ratio mismatch
`timescale 1ns/1ps

module acscc_ratio_check
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        check_enable,
  input  wire logic        source_level,
  input  wire logic        frame_level,
  input  wire logic        falling_edge,
  input  wire logic [13:0] ratio,
  output logic             ratio_error
);

  acscc_pkg::acscc_check_state_type state;
  logic        source_prev;
  logic        frame_prev;
  logic        source_edge;
  logic        frame_start;
  logic [14:0] count;
  logic [14:0] learned;
  logic        learned_valid;
  logic [14:0] expected;
  logic        mismatch;

  // Edge detection on the sampled clock and frame sync
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      source_prev <= 1'b0;
      frame_prev  <= 1'b0;
    end
    else
    begin
      source_prev <= source_level;
      frame_prev  <= frame_level;
    end
  end

  assign source_edge = falling_edge ? (source_prev & ~source_level)
                                    : (~source_prev & source_level);
  assign frame_start = ~frame_prev & frame_level;
  assign expected    = (ratio == 14'h0) ? learned : {1'b0, ratio};
  assign mismatch    = (count != expected);

  // First frame only opens the count window, since no full frame has been seen
  always_ff @(posedge clock)
  begin
    if (!rst_n || !check_enable)
      state <= acscc_pkg::acscc_idle;
    else
      unique case (state)
        acscc_pkg::acscc_idle:        state <= acscc_pkg::acscc_first_frame;
        acscc_pkg::acscc_first_frame: if (frame_start) state <= acscc_pkg::acscc_measure;
        acscc_pkg::acscc_measure:     state <= acscc_pkg::acscc_measure;
        default:                      state <= acscc_pkg::acscc_idle;
      endcase
  end

  // Edge count per frame, saturating so a stopped frame sync cannot wrap
  always_ff @(posedge clock)
  begin
    if (!rst_n || frame_start)
      count <= {14'h0, source_edge};
    else if (source_edge && count != 15'h7fff)
      count <= count + 15'h1;
  end

  // Auto mode learns the first full frame and checks against it
  always_ff @(posedge clock)
  begin
    if (!rst_n || !check_enable || ratio != 14'h0)
    begin
      learned       <= 15'h0;
      learned_valid <= 1'b0;
    end
    else if (state == acscc_pkg::acscc_measure && frame_start && !learned_valid)
    begin
      learned       <= count;
      learned_valid <= 1'b1;
    end
  end

  // Flag follows each frame: set on mismatch, cleared on match
  always_ff @(posedge clock)
  begin
    if (!rst_n || !check_enable)
      ratio_error <= 1'b0;
    else if (state == acscc_pkg::acscc_measure && frame_start
             && (ratio != 14'h0 || learned_valid))
      ratio_error <= mismatch;
  end

  a_flag_on_frame: assert property (@(posedge clock) disable iff (!rst_n)
    !$stable(ratio_error) |-> $past(frame_start) || !$past(check_enable))
    else $error("ratio flag changed outside a frame start");

  a_fixed_mismatch: assert property (@(posedge clock) disable iff (!rst_n)
    (check_enable && state == acscc_pkg::acscc_measure && frame_start && ratio != 14'h0
     && count != {1'b0, ratio}) ##1 check_enable |-> ratio_error)
    else $error("programmed ratio mismatch not flagged");

  a_edge_select: assert property (@(posedge clock) disable iff (!rst_n)
    (falling_edge && source_prev && !source_level) |-> source_edge)
    else $error("falling edge not counted");

endmodule // acscc_ratio_check

// ---- hdl/acscc_clock_config.sv ----
// Clock source configuration registers and reference clock selection
`timescale 1ns/1ps
`include "acscc_map.svh"

module acscc_clock_config
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               reg_address,
  input  wire logic [7:0]               reg_write_data,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [7:0]               reg_read_data,
  input  wire logic                     auto_clock_mode,
  input  wire logic                     processing_load_high,
  input  wire logic                     primary_bit_clock,
  input  wire logic                     primary_frame_sync,
  input  wire logic                     secondary_bit_clock,
  input  wire logic                     secondary_frame_sync,
  input  wire logic                     controller_ref_clock,
  input  wire logic                     oscillator_clock,
  output logic                          ref_clock,
  output logic                          ref_source_valid,
  output logic                          pdm_bit_clock,
  output acscc_pkg::acscc_clk_ctrl_type clk_ctrl,
  output logic                          ratio_error
);

  logic [7:0]  source_cfg;
  logic [7:0]  ctrl_cfg0;
  logic [7:0]  ctrl_cfg1;
  logic [7:0]  ctrl_cfg2;
  logic [13:0] ref_ratio;
  logic [14:0] next_freq_khz;
  logic [2:0]  ref_source_choice;
  logic        pll_off;
  logic        pll_fractional_permit;
  logic        primary_port_role;
  logic        secondary_port_role;
  logic        controller_mode;
  logic        rate_family_select;
  logic        next_ref_clock;
  logic        next_source_valid;
  logic        check_frame;
  logic        next_pll_enable;
  logic [7:0]  next_read_data;

  localparam logic [15*8-1:0] FREQ_TABLE = `ACSCC_FREQ_KHZ_TABLE;

  // Field views of the stored registers
  assign pll_off               = source_cfg[`ACSCC_BIT_PLL_OFF];
  assign pll_fractional_permit = source_cfg[`ACSCC_BIT_FRAC_PERMIT];
  assign ref_source_choice     = source_cfg[`ACSCC_SRC_HI:`ACSCC_SRC_LO];
  assign primary_port_role     = ctrl_cfg2[`ACSCC_BIT_PRI_ROLE];
  assign secondary_port_role   = ctrl_cfg2[`ACSCC_BIT_SEC_ROLE];
  assign rate_family_select    = ctrl_cfg2[`ACSCC_BIT_FAMILY];
  assign controller_mode       = primary_port_role | secondary_port_role;

  // Register writes; reserved bits are stored as written and read back
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      source_cfg <= `ACSCC_RST_SOURCE_CFG;
      ctrl_cfg0  <= `ACSCC_RST_CTRL_CFG0;
      ctrl_cfg1  <= `ACSCC_RST_CTRL_CFG1;
      ctrl_cfg2  <= `ACSCC_RST_CTRL_CFG2;
    end
    else if (reg_write)
      unique case (reg_address)
        `ACSCC_OFF_SOURCE_CFG: source_cfg <= reg_write_data;
        `ACSCC_OFF_CTRL_CFG0:  ctrl_cfg0  <= reg_write_data;
        `ACSCC_OFF_CTRL_CFG1:  ctrl_cfg1  <= reg_write_data;
        `ACSCC_OFF_CTRL_CFG2:  ctrl_cfg2  <= reg_write_data;
        default:               source_cfg <= source_cfg;
      endcase
  end

  // High bits only stage; a low byte write commits both halves together
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ref_ratio <= {6'(`ACSCC_RST_CTRL_CFG0), `ACSCC_RST_CTRL_CFG1};
    else if (reg_write && reg_address == `ACSCC_OFF_CTRL_CFG1)
      ref_ratio <= {ctrl_cfg0[`ACSCC_RATIO_HIGH_HI:0], reg_write_data};
  end

  // Read data is registered; unmapped offsets read zero
  always_comb
  begin
    unique case (reg_address)
      `ACSCC_OFF_SOURCE_CFG: next_read_data = source_cfg;
      `ACSCC_OFF_CTRL_CFG0:  next_read_data = ctrl_cfg0;
      `ACSCC_OFF_CTRL_CFG1:  next_read_data = ctrl_cfg1;
      `ACSCC_OFF_CTRL_CFG2:  next_read_data = ctrl_cfg2;
      `ACSCC_OFF_ERR_STATUS: next_read_data = {ratio_error, 7'h00};
      default:               next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      reg_read_data <= 8'h00;
    else if (reg_read)
      reg_read_data <= next_read_data;
  end

  // Source selection; fixed reference needs a controller port, reserved codes select nothing
  always_comb
  begin
    next_ref_clock    = 1'b0;
    next_source_valid = 1'b1;
    check_frame       = primary_frame_sync;
    unique case (ref_source_choice)
      `ACSCC_SRC_PRI_BCLK: next_ref_clock = primary_bit_clock;
      `ACSCC_SRC_REF_PRI:  next_ref_clock = controller_ref_clock;
      `ACSCC_SRC_SEC_BCLK:
      begin
        next_ref_clock = secondary_bit_clock;
        check_frame    = secondary_frame_sync;
      end
      `ACSCC_SRC_REF_SEC:
      begin
        next_ref_clock = controller_ref_clock;
        check_frame    = secondary_frame_sync;
      end
      `ACSCC_SRC_FIXED_REF:
      begin
        next_ref_clock    = controller_ref_clock & controller_mode;
        next_source_valid = controller_mode;
        check_frame       = primary_port_role ? primary_frame_sync : secondary_frame_sync;
      end
      `ACSCC_SRC_INT_OSC:  next_ref_clock = oscillator_clock;
      default:             next_source_valid = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ref_clock        <= 1'b0;
      ref_source_valid <= 1'b0;
    end
    else
    begin
      ref_clock        <= next_ref_clock;
      ref_source_valid <= next_source_valid;
    end
  end

  // PLL enable: off wins, custom mode always on, auto mode follows load
  assign next_pll_enable = !pll_off && (!auto_clock_mode || processing_load_high);

  // Frequency lookup; code 7 sits in the top slice of the table
  assign next_freq_khz = FREQ_TABLE[ctrl_cfg2[`ACSCC_FREQ_HI:`ACSCC_FREQ_LO]*15 +: 15];

  // Control outputs are registered so downstream clocking sees clean levels
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      clk_ctrl <= '0;
    else
    begin
      clk_ctrl.pll_enable            <= next_pll_enable;
      clk_ctrl.pll_fractional_permit <= pll_fractional_permit && !pll_off;
      clk_ctrl.primary_port_role     <= primary_port_role;
      clk_ctrl.secondary_port_role   <= secondary_port_role;
      clk_ctrl.rate_family_select    <= rate_family_select;
      clk_ctrl.ref_freq_khz          <= next_freq_khz;
      clk_ctrl.ref_ratio             <= ref_ratio;
      clk_ctrl.ref_ratio_auto        <= (ref_ratio == 14'h0);
    end
  end

  // Checker only runs on a legal source; it uses the committed ratio in synced modes
  acscc_ratio_check u_ratio_check
  (
    .clock        (clock),
    .rst_n        (rst_n),
    .check_enable (next_source_valid),
    .source_level (next_ref_clock),
    .frame_level  (check_frame),
    .falling_edge (source_cfg[`ACSCC_BIT_EDGE]),
    .ratio        (ref_ratio),
    .ratio_error  (ratio_error)
  );

  // Pdm clock follows rate code and family
  acscc_pdm_clock u_pdm_clock
  (
    .clock              (clock),
    .rst_n              (rst_n),
    .pdm_rate_choice    (ctrl_cfg0[`ACSCC_PDM_HI:`ACSCC_PDM_LO]),
    .rate_family_select (rate_family_select),
    .pdm_bit_clock      (pdm_bit_clock)
  );

  a_pll_off_wins: assert property (@(posedge clock) disable iff (!rst_n)
    pll_off |=> !clk_ctrl.pll_enable)
    else $error("pll enabled while off bit set");

  a_pll_custom_on: assert property (@(posedge clock) disable iff (!rst_n)
    (rst_n && !pll_off && !auto_clock_mode) |=> clk_ctrl.pll_enable)
    else $error("pll not enabled in custom mode");

  a_frac_permit: assert property (@(posedge clock) disable iff (!rst_n)
    clk_ctrl.pll_fractional_permit |-> $past(pll_fractional_permit))
    else $error("fractional mode without permit");

  a_ratio_whole: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_address == `ACSCC_OFF_CTRL_CFG0) |=> $stable(ref_ratio))
    else $error("ratio changed on high byte write");

  a_ratio_commit: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_write && reg_address == `ACSCC_OFF_CTRL_CFG1) |=>
      ref_ratio == {$past(ctrl_cfg0[5:0]), $past(reg_write_data)} ##1
      clk_ctrl.ref_ratio == $past(ref_ratio))
    else $error("ratio not committed whole");

  a_src_primary: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice == `ACSCC_SRC_PRI_BCLK) |=> ref_clock == $past(primary_bit_clock))
    else $error("primary bit clock not selected");

  a_fixed_needs_ctrl: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice == `ACSCC_SRC_FIXED_REF && !controller_mode) |=> !ref_source_valid)
    else $error("fixed reference valid in target mode");

  a_role_follow: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 clk_ctrl.primary_port_role == $past(primary_port_role)
        && clk_ctrl.secondary_port_role == $past(secondary_port_role))
    else $error("port role output wrong");

  a_family_follow: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 clk_ctrl.rate_family_select == $past(rate_family_select))
    else $error("rate family output wrong");

  a_freq_code_one: assert property (@(posedge clock) disable iff (!rst_n)
    (rst_n && ctrl_cfg2[7:5] == 3'h1) |=> clk_ctrl.ref_freq_khz == 15'h3000)
    else $error("code one not 12288 kHz");

  // The pll custom and auto load, fractional follow, frequency and auto flag antecedents also test rst_n, so the edge that releases reset starts no attempt
  // against outputs that were still cleared on that edge
  a_src_secondary: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice == `ACSCC_SRC_SEC_BCLK) |=> ref_clock == $past(secondary_bit_clock))
    else $error("secondary bit clock not selected");

  a_src_synced_ref: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice inside {`ACSCC_SRC_REF_PRI, `ACSCC_SRC_REF_SEC})
      |=> ref_clock == $past(controller_ref_clock))
    else $error("synced reference not selected");

  a_src_oscillator: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice == `ACSCC_SRC_INT_OSC) |=> ref_clock == $past(oscillator_clock))
    else $error("oscillator not selected");

  a_src_reserved: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice > `ACSCC_SRC_INT_OSC) |=> !ref_source_valid && !ref_clock)
    else $error("reserved source code selected a clock");

  a_fixed_with_ctrl: assert property (@(posedge clock) disable iff (!rst_n)
    (ref_source_choice == `ACSCC_SRC_FIXED_REF && controller_mode)
      |=> ref_source_valid && ref_clock == $past(controller_ref_clock))
    else $error("fixed reference not selected in controller mode");

  a_pll_auto_load: assert property (@(posedge clock) disable iff (!rst_n)
    (rst_n && !pll_off && auto_clock_mode)
      |=> clk_ctrl.pll_enable == $past(processing_load_high))
    else $error("pll does not follow load in auto mode");

  a_frac_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (rst_n && pll_fractional_permit && !pll_off) |=> clk_ctrl.pll_fractional_permit)
    else $error("fractional mode withheld despite permit");

  a_auto_flag: assert property (@(posedge clock) disable iff (!rst_n)
    rst_n |=> clk_ctrl.ref_ratio_auto == ($past(ref_ratio) == 14'h0))
    else $error("auto ratio flag wrong");

  a_status_read: assert property (@(posedge clock) disable iff (!rst_n)
    (reg_read && reg_address == `ACSCC_OFF_ERR_STATUS)
      |=> reg_read_data == {$past(ratio_error), 7'h00})
    else $error("status read does not show ratio flag");

  c_ratio_error: cover property (@(posedge clock) disable iff (!rst_n) $rose(ratio_error));
  c_fixed_ref: cover property (@(posedge clock) disable iff (!rst_n)
    ref_source_valid && ref_source_choice == `ACSCC_SRC_FIXED_REF);
  c_ratio_update: cover property (@(posedge clock) disable iff (!rst_n)
    reg_write && reg_address == `ACSCC_OFF_CTRL_CFG1);
  c_auto_pll: cover property (@(posedge clock) disable iff (!rst_n)
    auto_clock_mode && $rose(clk_ctrl.pll_enable));

endmodule // acscc_clock_config

// ---- testbench/acscc_port_model.sv ----
// Far-side audio port model: bit clock and frame sync at a set ratio
`timescale 1ns/1ps

module acscc_port_model
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [13:0] edges,
  output logic             bit_clock,
  output logic             frame_sync
);
  logic [14:0] phase;

  // Phase over one frame; both lines stand still low between runs
  always_ff @(posedge clock)
  begin
    if (!rst_n || !run)
      phase <= 15'h0000;
    else if (phase >= {edges, 1'b0} - 15'h0001) // A shorter frame set mid-frame still wraps
      phase <= 15'h0000;
    else
      phase <= phase + 15'h0001;
  end

  // Bit clock rises with the frame, so each frame holds exactly edges rises and falls
  assign bit_clock  = run & ~phase[0];
  assign frame_sync = run & (phase < {1'b0, edges});
endmodule // acscc_port_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the clock source configuration block
`timescale 1ns/1ps

module tb_top;
  logic                          clock          = 1'b0;
  logic                          rst_n          = 1'b0;
  logic [7:0]                    reg_address    = 8'h00;
  logic [7:0]                    reg_write_data = 8'h00;
  logic                          reg_write      = 1'b0;
  logic                          reg_read       = 1'b0;
  logic                          auto_mode      = 1'b0;
  logic                          load_high      = 1'b0;
  logic [5:0]                    src_lvl        = 6'h00;
  logic                          model_run      = 1'b0;
  logic [13:0]                   model_edges    = 14'h0008;
  logic [7:0]                    reg_read_data;
  logic                          m_bclk;
  logic                          m_fs;
  logic                          ref_clock;
  logic                          ref_source_valid;
  logic                          pdm_bit_clock;
  logic                          ratio_error;
  acscc_pkg::acscc_clk_ctrl_type clk_ctrl;
  int                            errors         = 0;
  int                            cmp_count      = 0;

  // Clock at 250 MHz
  always #2 clock = ~clock;

  // Source levels: 0 pri bit clock, 1 pri frame, 2 sec bit clock, 3 sec frame, 4 ref, 5 osc
  acscc_clock_config uut (
    .clock(clock), .rst_n(rst_n), .reg_address(reg_address),
    .reg_write_data(reg_write_data), .reg_write(reg_write), .reg_read(reg_read),
    .reg_read_data(reg_read_data), .auto_clock_mode(auto_mode),
    .processing_load_high(load_high),
    .primary_bit_clock(model_run ? m_bclk : src_lvl[0]),
    .primary_frame_sync(model_run ? m_fs : src_lvl[1]),
    .secondary_bit_clock(src_lvl[2]), .secondary_frame_sync(src_lvl[3]),
    .controller_ref_clock(model_run ? m_bclk : src_lvl[4]),
    .oscillator_clock(src_lvl[5]), .ref_clock(ref_clock),
    .ref_source_valid(ref_source_valid), .pdm_bit_clock(pdm_bit_clock),
    .clk_ctrl(clk_ctrl), .ratio_error(ratio_error));

  acscc_port_model port (
    .clock(clock), .rst_n(rst_n), .run(model_run), .edges(model_edges),
    .bit_clock(m_bclk), .frame_sync(m_fs));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Writes keep reserved bits at their reset value of zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_address    <= a;
    reg_write_data <= d;
    reg_write      <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_address <= a;
    reg_read    <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(16'(reg_read_data), 16'(e));
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic t_reset();
    rd(8'h34, 8'h40);
    rd(8'h35, 8'h00);
    rd(8'h36, 8'h00);
    rd(8'h37, 8'h20);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    rd(8'h50, 8'h00);
    chk(16'(clk_ctrl.pll_fractional_permit), 16'h1);
    chk(16'(clk_ctrl.ref_freq_khz), 16'd12288);
    chk(16'(clk_ctrl.pll_enable), 16'h1);
    $display("reset test done");
  endtask

  task automatic t_pll();
    wr(8'h34, 8'h80);
    settle();
    chk(16'({clk_ctrl.pll_enable, clk_ctrl.pll_fractional_permit}), 16'h0);
    wr(8'h34, 8'h00);
    rd(8'h34, 8'h00);
    chk(16'({clk_ctrl.pll_enable, clk_ctrl.pll_fractional_permit}), 16'h2);
    wr(8'h34, 8'h40);
    @(posedge clock);
    auto_mode <= 1'b1;
    settle();
    chk(16'(clk_ctrl.pll_enable), 16'h0);
    @(posedge clock);
    load_high <= 1'b1;
    settle();
    chk(16'({clk_ctrl.pll_enable, clk_ctrl.pll_fractional_permit}), 16'h3);
    @(posedge clock);
    auto_mode <= 1'b0;
    load_high <= 1'b0;
    $display("pll test done");
  endtask

  task automatic t_ctrl();
    int f[8] = '{12000, 12288, 13000, 16000, 19200, 19680, 24000, 24576};
    logic [2:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      wr(8'h37, {c, c[1], c[0], 2'b00, c[2]});
      settle();
      chk(16'(clk_ctrl.ref_freq_khz), 16'(f[i]));
      chk(16'({clk_ctrl.primary_port_role, clk_ctrl.secondary_port_role}),
          16'(c[1:0]));
      chk(16'(clk_ctrl.rate_family_select), 16'(c[2]));
    end
    wr(8'h37, 8'h20);
    $display("control test done");
  endtask

  // A lone high-byte write must leave the used ratio alone
  task automatic t_ratio();
    wr(8'h35, 8'h3f);
    rd(8'h35, 8'h3f);
    chk(16'(clk_ctrl.ref_ratio), 16'h0);
    wr(8'h36, 8'hff);
    settle();
    chk(16'({clk_ctrl.ref_ratio_auto, clk_ctrl.ref_ratio}), 16'h3fff);
    wr(8'h35, 8'h00);
    settle();
    chk(16'(clk_ctrl.ref_ratio), 16'h3fff);
    wr(8'h36, 8'h00);
    settle();
    chk(16'({clk_ctrl.ref_ratio_auto, clk_ctrl.ref_ratio}), 16'h4000);
    $display("ratio test done");
  endtask

  task automatic t_source();
    int idx[6] = '{0, 4, 2, 4, 0, 5};
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h34, 8'(8'h40 | (c << 1)));
      if (c == 4 || c > 5)
      begin
        settle();
        chk(16'({ref_source_valid, ref_clock}), 16'h0);
      end
      else
      begin
        @(posedge clock);
        src_lvl <= 6'(1 << idx[c]);
        settle();
        chk(16'({ref_source_valid, ref_clock}), 16'h3);
        @(posedge clock);
        src_lvl <= ~6'(1 << idx[c]);
        settle();
        chk(16'(ref_clock), 16'h0);
      end
    end
    wr(8'h37, 8'h30);
    wr(8'h34, 8'h48);
    settle();
    chk(16'(ref_source_valid), 16'h1);
    wr(8'h37, 8'h20);
    $display("source test done");
  endtask

  task automatic t_pdm();
    int m4[4] = '{4, 2, 1, 8};
    longint exp_cnt;
    int cnt;
    logic prev;
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h35, {2'(k), 6'h00});
      wr(8'h37, k == 4 ? 8'h21 : 8'h20);
      exp_cnt = 64'd5000 * (k == 4 ? 2822400 : 3072000) * m4[k % 4] / 1000000000;
      settle();
      cnt = 0;
      prev = pdm_bit_clock;
      repeat (5000)
      begin
        @(negedge clock);
        if (pdm_bit_clock && !prev)
          cnt++;
        prev = pdm_bit_clock;
      end
      chk(16'(cnt + 1 >= exp_cnt && cnt <= exp_cnt + 1), 16'h1);
    end
    wr(8'h35, 8'h00);
    wr(8'h37, 8'h20);
    $display("pdm test done");
  endtask

  // Frames of the port model against a programmed ratio of eight
  task automatic t_check();
    wr(8'h34, 8'h42);
    wr(8'h36, 8'h08);
    @(posedge clock);
    model_run <= 1'b1;
    repeat (100) @(posedge clock);
    #1 chk(16'(ratio_error), 16'h0);
    @(posedge clock);
    model_edges <= 14'h0009;
    repeat (100) @(posedge clock);
    #1 chk(16'(ratio_error), 16'h1);
    rd(8'h3c, 8'h80);
    wr(8'h34, 8'h43);
    @(posedge clock);
    model_edges <= 14'h0008;
    repeat (100) @(posedge clock);
    #1 chk(16'(ratio_error), 16'h0);
    // Auto ratio learns the running frame of eight, then a longer frame must be flagged
    wr(8'h36, 8'h00);
    repeat (100) @(posedge clock);
    #1 chk(16'(ratio_error), 16'h0);
    @(posedge clock);
    model_edges <= 14'h0009;
    repeat (100) @(posedge clock);
    #1 chk(16'(ratio_error), 16'h1);
    @(posedge clock);
    model_run <= 1'b0;
    $display("ratio check test done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the roughly 26000 cycles the tests take
  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    stop_test();
  end

  // Reset for four cycles, then the scenarios
  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_pll();
    t_ctrl();
    t_ratio();
    t_source();
    t_pdm();
    t_check();
    stop_test();
  end
endmodule // tb_top
